// >>> design/fsp_sector_protect.sv
/*
 fsp_sector_protect: per-sector persistent and dynamic lock bits, global
 persistent freeze and password unlock, with an Avalon-MM slave.
 Assumes rstn is power-up, hw_reset_n is the asynchronous reset pin,
 and the array engine starts on arr_go.
*/
// Chosen here: register access over Avalon-MM and the register addresses.
// Operation
// - one persistent lock per sector; programmed singly, erased all together.
// - persistent programming blocks reads of bank zero and the target bank.
// - after entry the selected bank shows lock state; exit restores it.
// - with freeze set, persistent program and erase time out unchanged.
// - array change to protected sector is dropped after brief polling.
// - one dynamic lock per sector; set writes 0, clear writes 1.
// - dynamic locks are 0 after power-up and reset.
// - dynamic lock matters only when persistent lock is erased.
// - no polling for dynamic lock change; reads may be synchronous.
// - one global freeze; 0 locks persistent bits, 1 allows changes.
// - freeze clears only on reset, or password unlock in password mode.
// - password mode forces freeze to 0 at reset; exact password clears.
// - unlock takes effect about 1 us after a valid password.
// - password programming only clears bits; setting one times out.
// - password-mode lock hides the password and blocks its programming.
// - only the two lowest word bits select a password word.
// - password entry disables bank zero, other banks stay usable.
// - protected unless both persistent and dynamic bits are 1.
`timescale 1ns/1ps
`include "fsp_map.svh"

module fsp_sector_protect
	import fsp_pkg::*;
#(
	parameter int unsigned NUM_SECTORS  = 16,
	parameter int unsigned NUM_BANKS    = 4,
	parameter int unsigned PROG_CYCLES  = 64,
	parameter int unsigned FAIL_CYCLES  = 64,
	parameter int unsigned POLL_CYCLES  = 8
) (
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire logic                 clk_en,
	input  wire logic                 hw_reset_n,
	input  wire logic [2:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	output logic      [NUM_BANKS-1:0] bank_rd_en,
	output logic      [NUM_BANKS-1:0] bank_wr_en,
	output logic      [NUM_BANKS-1:0] bank_lock_view,
	output logic                      arr_go,
	output logic [$clog2(NUM_SECTORS)-1:0] arr_sector
);

	localparam int unsigned SW  = $clog2(NUM_SECTORS);
	localparam int unsigned BW  = $clog2(NUM_BANKS);
	localparam int unsigned SPB = NUM_SECTORS / NUM_BANKS;

	typedef struct packed {
		logic [1:0]             rst_sync;
		logic                   ack;
		logic [31:0]            rdata;
		logic [NUM_SECTORS-1:0] plock;
		logic [NUM_SECTORS-1:0] dlock;
		logic [63:0]            pw;
		logic                   pw_mode;
		logic                   freeze;
		logic [15:0]            data;
		logic [SW-1:0]          sel;
		logic [1:0]             sel_word;
		logic [3:0]             last_op;
		fsp_state_type          st;
		logic [15:0]            timer;
		logic [3:0]             op;
		logic [SW-1:0]          tgt;
		logic [BW-1:0]          view_bank;
		logic                   plock_view;
		logic                   pw_view;
		logic [63:0]            ubuf;
		logic [3:0]             umask;
		logic                   timed_out;
		logic                   refused;
		logic                   arr_go;
		logic [SW-1:0]          arr_sector;
	} fsp_regs_type;

	fsp_regs_type cur;
	fsp_regs_type nxt;

	// bank that holds a sector
	function automatic logic [BW-1:0] bank_of(input logic [SW-1:0] s);
		bank_of = BW'(32'(s) / SPB);
	endfunction

	// sector protection from its two lock bits; freeze plays no part
	function automatic logic is_protected(input logic p, input logic d);
		is_protected = ~(p & d);
	endfunction

	// one access takes two cycles: request seen, then answered
	assign avs_waitrequest = (avs_read | avs_write) & ~cur.ack;
	assign avs_readdata    = cur.rdata;
	assign arr_go          = cur.arr_go;
	assign arr_sector      = cur.arr_sector;

	// bank access gating from the entry modes and the sequencer
	always_comb begin
		logic pl_busy;
		pl_busy = 1'b0;
		pl_busy = (cur.st == ST_PROG) &&
			(cur.op == `FSP_OP_PL_PROG || cur.op == `FSP_OP_PL_ERASE);
		for (int b = 0; b < NUM_BANKS; b++) begin
			bank_lock_view[b] = cur.plock_view &&
				(cur.view_bank == BW'(b));
			bank_rd_en[b] = 1'b1;
			if (cur.pw_view && b == 0) begin
				bank_rd_en[b] = 1'b0;
			end
			if (bank_lock_view[b]) begin
				bank_rd_en[b] = 1'b0;
			end
			if (pl_busy && (b == 0 || bank_of(cur.tgt) == BW'(b))) begin
				bank_rd_en[b] = 1'b0;
			end
			// writes stay off everywhere while locks are being viewed
			bank_wr_en[b] = ~cur.plock_view &&
				~(cur.pw_view && b == 0) && (cur.st == ST_IDLE);
		end
	end

	// next state of everything
	always_comb begin
		logic [31:0] rd;
		logic        wr;
		logic [3:0]  op;
		logic [SW-1:0] sec;
		logic [1:0]  wd;
		logic [3:0]  m;
		logic [15:0] pw_word;
		rd      = 32'h0;
		wr      = avs_write & cur.ack & (avs_byteenable == 4'hF);
		op      = avs_writedata[`FSP_CMD_OP_LSB +: 4];
		sec     = avs_writedata[`FSP_CMD_SEC_LSB +: SW];
		wd      = avs_writedata[`FSP_CMD_WORD_LSB +: 2];
		m       = 4'h0;
		pw_word = cur.pw[{wd, 4'h0} +: 16];
		nxt     = cur;
		nxt.rst_sync = {cur.rst_sync[0], hw_reset_n};
		nxt.ack      = (avs_read | avs_write) & ~cur.ack;
		nxt.arr_go   = 1'b0;

		// read mux; unmapped words read as zero
		case (avs_address)
		`FSP_REG_CMD: begin
			rd[3:0] = cur.last_op;
		end
		`FSP_REG_DATA: begin
			rd[15:0] = cur.data;
		end
		`FSP_REG_STATUS: begin
			rd[`FSP_ST_BUSY]    = (cur.st != ST_IDLE);
			rd[`FSP_ST_FREEZE]  = cur.freeze;
			rd[`FSP_ST_PWMODE]  = cur.pw_mode;
			rd[`FSP_ST_PLVIEW]  = cur.plock_view;
			rd[`FSP_ST_PWVIEW]  = cur.pw_view;
			rd[`FSP_ST_TIMEOUT] = cur.timed_out;
			rd[`FSP_ST_REFUSED] = cur.refused;
		end
		`FSP_REG_SEL: begin
			rd[SW-1:0] = cur.sel;
			rd[`FSP_SEL_WORD_LSB +: 2] = cur.sel_word;
		end
		`FSP_REG_SECTOR: begin
			rd[0] = cur.plock[cur.sel];
			rd[1] = cur.dlock[cur.sel];
			rd[2] = is_protected(cur.plock[cur.sel], cur.dlock[cur.sel]);
		end
		`FSP_REG_PWRD: begin
			// a locked password mode never shows the password
			if (cur.pw_view && !cur.pw_mode) begin
				rd[15:0] = cur.pw[{cur.sel_word, 4'h0} +: 16];
			end
		end
		`FSP_REG_BANKS: begin
			rd[NUM_BANKS-1:0] = bank_rd_en;
			rd[`FSP_BANKS_WR_LSB +: NUM_BANKS] = bank_wr_en;
			rd[`FSP_BANKS_VIEW_LSB +: NUM_BANKS] = bank_lock_view;
		end
		default: begin
			rd = 32'h0;
		end
		endcase
		if (avs_read && !cur.ack) begin
			nxt.rdata = rd;
		end

		// write-one-to-clear of sticky flags; events below win
		if (wr && avs_address == `FSP_REG_STATUS) begin
			if (avs_writedata[`FSP_ST_TIMEOUT]) begin
				nxt.timed_out = 1'b0;
			end
			if (avs_writedata[`FSP_ST_REFUSED]) begin
				nxt.refused = 1'b0;
			end
		end
		if (wr && avs_address == `FSP_REG_DATA) begin
			nxt.data = avs_writedata[15:0];
		end
		if (wr && avs_address == `FSP_REG_SEL) begin
			nxt.sel      = avs_writedata[SW-1:0];
			nxt.sel_word = avs_writedata[`FSP_SEL_WORD_LSB +: 2];
		end

		// command sequencer
		case (cur.st)
		ST_IDLE: begin
			if (wr && avs_address == `FSP_REG_CMD) begin
				nxt.last_op = op;
				nxt.op      = op;
				nxt.tgt     = sec;
				case (op)
				`FSP_OP_PL_ENTER: begin
					nxt.plock_view = 1'b1;
					nxt.view_bank  = bank_of(sec);
				end
				`FSP_OP_PL_EXIT: begin
					nxt.plock_view = 1'b0;
				end
				`FSP_OP_PL_PROG, `FSP_OP_PL_ERASE: begin
					if (!cur.plock_view) begin
						nxt.refused = 1'b1;
					end else if (!cur.freeze) begin
						nxt.st    = ST_FAIL;
						nxt.timer = 16'(FAIL_CYCLES - 1);
					end else begin
						nxt.st    = ST_PROG;
						nxt.timer = 16'(PROG_CYCLES - 1);
					end
				end
				`FSP_OP_DL_SET: begin
					nxt.dlock[sec] = 1'b0;
				end
				`FSP_OP_DL_CLEAR: begin
					nxt.dlock[sec] = 1'b1;
				end
				`FSP_OP_FREEZE_SET: begin
					nxt.freeze = 1'b0;
				end
				`FSP_OP_PW_ENTER: begin
					nxt.pw_view = 1'b1;
					nxt.umask   = 4'h0;
				end
				`FSP_OP_PW_EXIT: begin
					nxt.pw_view = 1'b0;
					nxt.umask   = 4'h0;
				end
				`FSP_OP_PW_PROG: begin
					if (!cur.pw_view || cur.pw_mode) begin
						nxt.refused = 1'b1;
					end else if ((cur.data & ~pw_word) != 16'h0000) begin
						// a cell at 0 cannot go back to 1
						nxt.pw[{wd, 4'h0} +: 16] = pw_word & cur.data;
						nxt.st    = ST_FAIL;
						nxt.timer = 16'(FAIL_CYCLES - 1);
					end else begin
						nxt.pw[{wd, 4'h0} +: 16] = pw_word & cur.data;
						nxt.st    = ST_PROG;
						nxt.timer = 16'(PROG_CYCLES - 1);
					end
				end
				`FSP_OP_PW_UNLOCK: begin
					if (!cur.pw_view || !cur.pw_mode) begin
						nxt.refused = 1'b1;
					end else begin
						nxt.ubuf[{wd, 4'h0} +: 16] = cur.data;
						m = cur.umask | (4'h1 << wd);
						nxt.umask = m;
						if (m == 4'hF) begin
							nxt.umask = 4'h0;
							if (nxt.ubuf == cur.pw) begin
								nxt.st    = ST_UNLOCK;
								nxt.timer = 16'(`FSP_UNLOCK_CYCLES - 1);
							end else begin
								nxt.refused = 1'b1;
							end
						end
					end
				end
				`FSP_OP_PWMODE_LOCK: begin
					nxt.pw_mode = 1'b1;
				end
				`FSP_OP_ARRAY_PROG: begin
					if (is_protected(cur.plock[sec], cur.dlock[sec])) begin
						nxt.st    = ST_POLL;
						nxt.timer = 16'(POLL_CYCLES - 1);
					end else begin
						nxt.arr_go     = 1'b1;
						nxt.arr_sector = sec;
					end
				end
				default: begin
					nxt.op = `FSP_OP_NOP;
				end
				endcase
			end
		end
		ST_PROG: begin
			if (cur.timer == 16'h0000) begin
				nxt.st = ST_IDLE;
				case (cur.op)
				`FSP_OP_PL_PROG: begin
					nxt.plock[cur.tgt] = 1'b0;
				end
				`FSP_OP_PL_ERASE: begin
					nxt.plock = '1;
				end
				default: begin
					nxt.st = ST_IDLE;
				end
				endcase
			end else begin
				nxt.timer = cur.timer - 16'h0001;
			end
		end
		ST_FAIL: begin
			if (cur.timer == 16'h0000) begin
				nxt.st        = ST_IDLE;
				nxt.timed_out = 1'b1;
			end else begin
				nxt.timer = cur.timer - 16'h0001;
			end
		end
		ST_POLL: begin
			// status polling stays up briefly, contents untouched
			if (cur.timer == 16'h0000) begin
				nxt.st      = ST_IDLE;
				nxt.refused = 1'b1;
			end else begin
				nxt.timer = cur.timer - 16'h0001;
			end
		end
		ST_UNLOCK: begin
			if (cur.timer == 16'h0000) begin
				nxt.st     = ST_IDLE;
				nxt.freeze = 1'b1;
			end else begin
				nxt.timer = cur.timer - 16'h0001;
			end
		end
		default: begin
			nxt.st = ST_IDLE;
		end
		endcase

		// a command while busy is dropped and flagged
		if (wr && avs_address == `FSP_REG_CMD && cur.st != ST_IDLE) begin
			nxt.refused = 1'b1;
		end

		// pin reset: volatile state only, nonvolatile cells survive
		if (!cur.rst_sync[1]) begin
			nxt.dlock      = '0;
			nxt.freeze     = ~cur.pw_mode;
			nxt.st         = ST_IDLE;
			nxt.timer      = 16'h0000;
			nxt.plock_view = 1'b0;
			nxt.pw_view    = 1'b0;
			nxt.umask      = 4'h0;
			nxt.timed_out  = 1'b0;
			nxt.refused    = 1'b0;
			nxt.arr_go     = 1'b0;
		end
	end

	// state register; rstn is power-up and loads plock and pw with erased all-ones values
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cur          <= '0;
			cur.plock    <= '1;
			cur.dlock    <= '0;
			cur.pw       <= `FSP_PW_RESET;
			cur.freeze   <= 1'b1;
			cur.st       <= ST_IDLE;
			cur.last_op  <= `FSP_OP_NOP;
			cur.op       <= `FSP_OP_NOP;
		end else if (clk_en) begin
			cur <= nxt;
		end
	end

endmodule

// >>> design/fsp_map.svh
/*
 fsp_map.svh: register word indices, field positions, command codes,
 reset values and timing counts of the sector protection block.
 Assumes a 200 MHz system clock and Avalon-MM word addressing.
*/
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

// register word indices on the avalon slave
`define FSP_REG_CMD        3'h0
`define FSP_REG_DATA       3'h1
`define FSP_REG_STATUS     3'h2
`define FSP_REG_SEL        3'h3
`define FSP_REG_SECTOR     3'h4
`define FSP_REG_PWRD       3'h5
`define FSP_REG_BANKS      3'h6

// field positions
`define FSP_CMD_OP_LSB     0
`define FSP_CMD_SEC_LSB    8
`define FSP_CMD_WORD_LSB   16
`define FSP_SEL_WORD_LSB   8
`define FSP_BANKS_WR_LSB   8
`define FSP_BANKS_VIEW_LSB 16
`define FSP_ST_BUSY        0
`define FSP_ST_FREEZE      1
`define FSP_ST_PWMODE      2
`define FSP_ST_PLVIEW      3
`define FSP_ST_PWVIEW      4
`define FSP_ST_TIMEOUT     5
`define FSP_ST_REFUSED     6

// command codes
`define FSP_OP_NOP         4'h0
`define FSP_OP_PL_ENTER    4'h1
`define FSP_OP_PL_EXIT     4'h2
`define FSP_OP_PL_PROG     4'h3
`define FSP_OP_PL_ERASE    4'h4
`define FSP_OP_DL_SET      4'h5
`define FSP_OP_DL_CLEAR    4'h6
`define FSP_OP_FREEZE_SET  4'h7
`define FSP_OP_PW_ENTER    4'h8
`define FSP_OP_PW_EXIT     4'h9
`define FSP_OP_PW_PROG     4'hA
`define FSP_OP_PW_UNLOCK   4'hB
`define FSP_OP_PWMODE_LOCK 4'hC
`define FSP_OP_ARRAY_PROG  4'hD

// reset values
`define FSP_PW_RESET       64'hFFFF_FFFF_FFFF_FFFF

// timing
`define FSP_CLK_PERIOD_NS  5
`define FSP_UNLOCK_TIME_NS 1000
`define FSP_UNLOCK_CYCLES  (`FSP_UNLOCK_TIME_NS / `FSP_CLK_PERIOD_NS)

`endif

// >>> design/fsp_pkg.sv
/*
 fsp_pkg: types shared by the sector protection block.
 Assumes nothing of its surroundings.
*/
package fsp_pkg;

	// sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROG,
		ST_FAIL,
		ST_POLL,
		ST_UNLOCK
	} fsp_state_type;

endpackage

// >>> testbench/fsp_sector_protect_monitor.sv
/*
 port-level checker for fsp_sector_protect.
 Sees only the top ports; bound in below the module.
*/
`timescale 1ns/1ps
`include "fsp_map.svh"
module fsp_sector_protect_monitor #(
	parameter int unsigned NUM_SECTORS = 16,
	parameter int unsigned NUM_BANKS   = 4
) (
	input wire logic                           sys_clk,
	input wire logic                           rstn,
	input wire logic                           hw_reset_n,
	input wire logic [2:0]                     avs_address,
	input wire logic                           avs_read,
	input wire logic                           avs_write,
	input wire logic [31:0]                    avs_writedata,
	input wire logic [3:0]                     avs_byteenable,
	input wire logic [31:0]                    avs_readdata,
	input wire logic                           avs_waitrequest,
	input wire logic [NUM_BANKS-1:0]           bank_rd_en,
	input wire logic [NUM_BANKS-1:0]           bank_wr_en,
	input wire logic [NUM_BANKS-1:0]           bank_lock_view,
	input wire logic                           arr_go,
	input wire logic [$clog2(NUM_SECTORS)-1:0] arr_sector
);
	logic                           go_cmd;
	logic [$clog2(NUM_SECTORS)-1:0] last_sec;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// committed array program command, and the sector it named
	assign go_cmd = avs_write & ~avs_waitrequest & (avs_byteenable == 4'hF)
		& (avs_address == `FSP_REG_CMD) & (avs_writedata[3:0] == `FSP_OP_ARRAY_PROG);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			last_sec <= '0;
		else if (go_cmd)
			last_sec <= avs_writedata[8 +: $clog2(NUM_SECTORS)];
	end

	sequence s_req_start;
		$rose(avs_read | avs_write);
	endsequence
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest;
	endsequence

	property p_ack;
		s_req_start |-> s_one_wait;
	endproperty
	a_ack: assert property (p_ack) else $error("waitrequest not one cycle");
	property p_idle;
		!(avs_read | avs_write) |-> !avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("waitrequest while idle");
	property p_go_pulse;
		arr_go |=> !arr_go;
	endproperty
	a_go_pulse: assert property (p_go_pulse) else $error("array start too long");
	property p_go_cause;
		arr_go |-> $past(go_cmd, 1) || $past(go_cmd, 2);
	endproperty
	a_go_cause: assert property (p_go_cause) else $error("array start uncaused");
	property p_go_sector;
		arr_go |-> arr_sector == last_sec;
	endproperty
	a_go_sector: assert property (p_go_sector) else $error("array start wrong sector");
	property p_view_wr;
		(bank_lock_view & bank_wr_en) == '0;
	endproperty
	a_view_wr: assert property (p_view_wr) else $error("viewed bank writable");
	property p_hw_banks;
		!hw_reset_n [*4] |-> bank_lock_view == '0 && &bank_rd_en && &bank_wr_en;
	endproperty
	a_hw_banks: assert property (p_hw_banks) else $error("banks not restored by reset");
	property p_rdata;
		!(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
	endproperty
	a_rdata: assert property (p_rdata) else $error("readdata changed unasked");
endmodule

bind fsp_sector_protect fsp_sector_protect_monitor #(
	.NUM_SECTORS(NUM_SECTORS), .NUM_BANKS(NUM_BANKS)) u_mon (
	.sys_clk(sys_clk), .rstn(rstn), .hw_reset_n(hw_reset_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .bank_rd_en(bank_rd_en), .bank_wr_en(bank_wr_en),
	.bank_lock_view(bank_lock_view), .arr_go(arr_go), .arr_sector(arr_sector));

// >>> testbench/fsp_host_bfm.sv
/*
 fsp_host_bfm: host controller issuing avalon accesses.
 Assumes the slave answers with waitrequest; wait is bounded.
*/
`timescale 1ns/1ps
module fsp_host_bfm (
	input wire logic         sys_clk,
	input wire logic         avs_waitrequest,
	input wire logic  [31:0] avs_readdata,
	output logic      [2:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata,
	output logic             hung
);
	// idle bus at time zero
	initial begin
		avs_address = 3'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hung = 1'b0;
	end

	// one access; a single read or write, no burst
	task automatic xfer(input logic [2:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		avs_writedata <= ~d; // released data is not left looking valid
		if (n >= 64)
			hung <= 1'b1;
	endtask
endmodule

// >>> testbench/tb.sv
/*
 tb: self-checking bench for fsp_sector_protect.
 Host model drives the slave; program, fail and poll counts shortened to 4.
*/
`timescale 1ns/1ps
`include "fsp_map.svh"
module tb;
	import fsp_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        hw_reset_n = 1'b1;
	int          errors = 0;
	int          check_count = 0;
	int          go_n = 0;
	logic [3:0]  go_sec = 4'h0;
	logic [31:0] q;
	wire logic [2:0]  avs_address;
	wire logic        avs_read, avs_write, avs_waitrequest, arr_go, hung;
	wire logic [31:0] avs_writedata, avs_readdata;
	wire logic [3:0]  bank_rd_en, bank_wr_en, bank_lock_view, arr_sector;

	always #2.5 sys_clk = ~sys_clk;

	fsp_sector_protect #(.PROG_CYCLES(4), .FAIL_CYCLES(4), .POLL_CYCLES(4)) i_fsp_sector_protect (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .hw_reset_n(hw_reset_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .bank_rd_en(bank_rd_en), .bank_wr_en(bank_wr_en),
		.bank_lock_view(bank_lock_view), .arr_go(arr_go), .arr_sector(arr_sector));
	fsp_host_bfm host (.sys_clk(sys_clk), .avs_waitrequest(avs_waitrequest),
		.avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .hung(hung));

	// count array starts seen at the port
	always @(posedge sys_clk) begin
		if (arr_go === 1'b1) begin
			go_n <= go_n + 1;
			go_sec <= arr_sector;
		end
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge hung) begin
		errors++;
		$display("[FAIL] %0t bus access never answered", $time);
		test_done();
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(a, 1'b1, d, r);
	endtask
	task automatic rd(input logic [2:0] a);
		host.xfer(a, 1'b0, 32'h0, q);
	endtask
	// sector rides with the command word
	task automatic cmd(input logic [3:0] op, input logic [7:0] s, input logic [1:0] w);
		wr(`FSP_REG_CMD, {14'h0, w, s, 4'h0, op});
	endtask
	task automatic sec(input logic [7:0] s);
		wr(`FSP_REG_SEL, {24'h0, s});
		rd(`FSP_REG_SECTOR);
	endtask
	// poll busy; a stuck busy ends the run
	task automatic idle;
		int n;
		n = 0;
		q = 32'h1;
		while (q[0] !== 1'b0 && n < 300) begin
			rd(`FSP_REG_STATUS);
			n++;
		end
		if (n >= 300) begin
			errors++;
			$display("[FAIL] %0t busy never cleared", $time);
			test_done();
		end
	endtask
	task automatic hwr;
		hw_reset_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		hw_reset_n <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask
	// four unlock words; only word one differs from all ones
	task automatic unlock(input logic [15:0] w1);
		for (int w = 0; w < 4; w++) begin
			wr(`FSP_REG_DATA, (w == 1) ? {16'h0, w1} : 32'hFFFF);
			cmd(`FSP_OP_PW_UNLOCK, 8'h0, w[1:0]);
		end
	endtask

	task automatic t_reset;
		rd(`FSP_REG_STATUS);
		chk(q[1:0], 2'h2, "freeze after reset");
		chk({bank_rd_en, bank_wr_en, bank_lock_view}, 12'hFF0, "banks after reset");
		sec(8'h3);
		chk(q[2:0], 3'h5, "sector after reset");
		$display("reset test done");
	endtask
	task automatic t_dyn;
		cmd(`FSP_OP_DL_CLEAR, 8'h3, 2'h0);
		sec(8'h3);
		chk(q[2:0], 3'h3, "dynamic clear");
		cmd(`FSP_OP_ARRAY_PROG, 8'h3, 2'h0);
		repeat (4) @(posedge sys_clk);
		chk(go_n, 1, "array start");
		chk(go_sec, 4'h3, "array sector");
		cmd(`FSP_OP_DL_SET, 8'h3, 2'h0);
		sec(8'h3);
		chk(q[2:0], 3'h5, "dynamic set");
		cmd(`FSP_OP_ARRAY_PROG, 8'h3, 2'h0);
		idle();
		rd(`FSP_REG_STATUS);
		chk(q[6], 1'h1, "protected array op refused");
		chk(go_n, 1, "no start on protected");
		wr(`FSP_REG_STATUS, 32'h60);
		$display("dynamic test done");
	endtask
	task automatic t_ppb;
		cmd(`FSP_OP_PL_ENTER, 8'h0, 2'h0);
		repeat (2) @(posedge sys_clk);
		chk({bank_wr_en, bank_lock_view}, 8'h01, "lock view entry");
		cmd(`FSP_OP_PL_PROG, 8'h0, 2'h0);
		repeat (2) @(posedge sys_clk);
		chk(bank_rd_en, 4'hE, "reads during lock program");
		idle();
		cmd(`FSP_OP_PL_PROG, 8'h1, 2'h0);
		idle();
		sec(8'h0);
		chk(q[2:0], 3'h4, "persistent programmed");
		cmd(`FSP_OP_DL_CLEAR, 8'h0, 2'h0);
		sec(8'h0);
		chk(q[2:0], 3'h6, "dynamic ignored");
		cmd(`FSP_OP_PL_ERASE, 8'h0, 2'h0);
		idle();
		sec(8'h0);
		chk(q[2:0], 3'h3, "erase all sector 0");
		sec(8'h1);
		chk(q[2:0], 3'h5, "erase all sector 1");
		cmd(`FSP_OP_PL_EXIT, 8'h0, 2'h0);
		repeat (2) @(posedge sys_clk);
		chk({bank_wr_en, bank_lock_view}, 8'hF0, "lock view exit");
		$display("persistent test done");
	endtask
	task automatic t_freeze;
		cmd(`FSP_OP_FREEZE_SET, 8'h0, 2'h0);
		rd(`FSP_REG_STATUS);
		chk(q[1], 1'h0, "freeze set");
		cmd(`FSP_OP_PL_ENTER, 8'h0, 2'h0);
		cmd(`FSP_OP_PL_PROG, 8'h2, 2'h0);
		idle();
		rd(`FSP_REG_STATUS);
		chk(q[5], 1'h1, "frozen program times out");
		sec(8'h2);
		chk(q[0], 1'h1, "frozen bit unchanged");
		cmd(`FSP_OP_PL_EXIT, 8'h0, 2'h0);
		cmd(`FSP_OP_PW_ENTER, 8'h0, 2'h0);
		unlock(16'hFFFF);
		idle();
		rd(`FSP_REG_STATUS);
		chk(q[1], 1'h0, "no unlock outside password mode");
		cmd(`FSP_OP_PW_EXIT, 8'h0, 2'h0);
		hwr();
		rd(`FSP_REG_STATUS);
		chk(q[1], 1'h1, "freeze cleared by reset");
		sec(8'h0);
		chk(q[2:0], 3'h5, "dynamic back to protected");
		$display("freeze test done");
	endtask
	task automatic t_pw;
		cmd(`FSP_OP_PW_ENTER, 8'h0, 2'h0);
		repeat (2) @(posedge sys_clk);
		chk({bank_rd_en, bank_wr_en}, 8'hEE, "bank zero off");
		wr(`FSP_REG_DATA, 32'h1234);
		cmd(`FSP_OP_PW_PROG, 8'h0, 2'h1);
		idle();
		wr(`FSP_REG_SEL, 32'h100);
		rd(`FSP_REG_PWRD);
		chk(q[15:0], 16'h1234, "password word");
		wr(`FSP_REG_DATA, 32'hFFFF);
		cmd(`FSP_OP_PW_PROG, 8'h0, 2'h1);
		idle();
		rd(`FSP_REG_STATUS);
		chk(q[5], 1'h1, "setting bits times out");
		rd(`FSP_REG_PWRD);
		chk(q[15:0], 16'h1234, "zeros kept");
		cmd(`FSP_OP_PWMODE_LOCK, 8'h0, 2'h0);
		rd(`FSP_REG_PWRD);
		chk(q, 32'h0, "password hidden");
		wr(`FSP_REG_DATA, 32'h0);
		cmd(`FSP_OP_PW_PROG, 8'h0, 2'h2);
		rd(`FSP_REG_STATUS);
		chk({q[6], q[0]}, 2'h2, "locked password program refused");
		cmd(`FSP_OP_PW_EXIT, 8'h0, 2'h0);
		hwr();
		rd(`FSP_REG_STATUS);
		chk(q[2:1], 2'h2, "password mode freezes");
		cmd(`FSP_OP_PW_ENTER, 8'h0, 2'h0);
		unlock(16'h1235);
		rd(`FSP_REG_STATUS);
		chk({q[6], q[1]}, 2'h2, "wrong password refused");
		wr(`FSP_REG_STATUS, 32'h60);
		repeat (200) @(posedge sys_clk);
		unlock(16'h1234);
		repeat (150) @(posedge sys_clk);
		rd(`FSP_REG_STATUS);
		chk(q[1:0], 2'h1, "unlock still pending");
		idle();
		rd(`FSP_REG_STATUS);
		chk(q[1], 1'h1, "unlock done");
		cmd(`FSP_OP_PW_EXIT, 8'h0, 2'h0);
		$display("password test done");
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge sys_clk);
		rstn <= 1'b1;
		t_reset();
		t_dyn();
		t_ppb();
		t_freeze();
		t_pw();
		test_done();
	end
endmodule
